/* rtl/status_flags_pkg.sv */
// package with status and option register layout, reset values and carriers
package status_flags_pkg;

   // ---------------------------------------------------------------
   // file register decode
   // ---------------------------------------------------------------
   localparam int          FILE_ADDR_W     = 9;       // bank bits plus 7-bit offset
   localparam int          BANK_OFS_W      = 7;       // offset inside a 128-byte bank
   localparam logic [6:0]  STATUS_OFS      = 7'h03;   // status alias offset in every bank
   localparam logic [6:0]  OPTION_OFS      = 7'h01;   // option offset in banks 1 and 3
   localparam int          OPTION_BANK_BIT = 7;       // address bit that marks banks 1 and 3

   // ---------------------------------------------------------------
   // status register fields
   // ---------------------------------------------------------------
   localparam int          ST_CARRY     = 0;
   localparam int          ST_NIBBLE    = 1;
   localparam int          ST_ZERO      = 2;
   localparam int          ST_SLEEP     = 3;
   localparam int          ST_TIMEOUT   = 4;
   localparam int          ST_DPAGE_LO  = 5;
   localparam int          ST_DPAGE_HI  = 6;
   localparam int          ST_IPAGE     = 7;
   localparam logic [7:0]  STATUS_RESET = 8'h18;      // flags set, banks zero, alu flags zero

   // ---------------------------------------------------------------
   // option register fields
   // ---------------------------------------------------------------
   localparam int          OP_RATE_LO   = 0;
   localparam int          OP_RATE_HI   = 2;
   localparam int          OP_ASSIGN    = 3;          // 1 = watchdog owns the prescaler
   localparam int          OP_T0_EDGE   = 4;
   localparam int          OP_T0_SRC    = 5;
   localparam int          OP_INT_EDGE  = 6;
   localparam int          OP_PULLUP_N  = 7;
   localparam logic [7:0]  OPTION_RESET = 8'hFF;

   // ---------------------------------------------------------------
   // carriers
   // ---------------------------------------------------------------
   typedef struct packed {
      logic zero;          // result is zero
      logic carry;         // carry out of bit 7 (add, rotate)
      logic nibble_carry;  // carry out of bit 3 (add)
      logic borrow;        // borrow out of bit 7 (subtract)
      logic nibble_borrow; // borrow out of bit 3 (subtract)
      logic is_sub;        // operation was a subtraction
   } alu_flags_s;

   typedef struct packed {
      logic zero;
      logic nibble;
      logic carry;
   } flag_mask_s;

endpackage

/* rtl/shared_prescaler.sv */
// shared 8-stage prescaler serving either the timer or the watchdog
`timescale 1ns/100ps
module shared_prescaler #(
   parameter int WIDTH = 8                      // counter stages
) (
   input  wire logic       clk_in,
   input  wire logic       rst_in,
   input  wire logic       tick_in,             // input event to divide
   input  wire logic       clear_in,            // restart the count
   input  wire logic [3:0] stages_in,           // divide by 2**stages_in
   output logic            tick_out             // divided event, one cycle
);
   logic [WIDTH-1:0] count;                     // ripple count of input events
   logic [WIDTH-1:0] low_mask;                  // bits that must all be ones

   // elaboration refuses a counter too short for the largest ratio
   if (WIDTH < 8) begin
      $error("shared_prescaler needs at least 8 stages");
   end

   // ---------------------------------------------------------------
   // counter
   // ---------------------------------------------------------------
   // count advances on every input event, restart wins over event
   always_ff @(posedge clk_in) begin
      if (rst_in || clear_in) begin
         count <= '0;
      end else if (tick_in) begin
         count <= count + 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // terminal decode
   // ---------------------------------------------------------------
   // output fires when the low stages roll over on this event
   always_comb begin
      low_mask = WIDTH'((1 << stages_in) - 1);
      tick_out = tick_in && !clear_in && ((count & low_mask) == low_mask);
   end

endmodule

/* rtl/cpu_status_flags_register.sv */
// processor status register with option register and shared prescaler routing
//
// Overview of operation
// - alu flags, reset cause, banks in one register
// - status accepts writes like any file register
// - flag-updating write blocks data to three flags
// - flags the op selects then follow the operation result, the rest hold
// - timeout and sleep flags ignore software writes
// - subtract reports borrow as inverted carry bits
// - status decoded at same offset in all banks
// - one prescaler, timer or watchdog, never both
// - option drives interrupt edge, timer source, pull-ups
// - status reachable regardless of direct page bits
`timescale 1ns/100ps
module cpu_status_flags_register #(
   parameter int PRESCALE_W = 8                          // prescaler stages
) (
   input  wire logic                                     clk_in,
   input  wire logic                                     rst_in,            // power-up reset
   input  wire logic [status_flags_pkg::FILE_ADDR_W-1:0] file_addr_in,      // full data address
   input  wire logic                                     file_wr_in,        // result write strobe
   input  wire logic [7:0]                               file_wdata_in,     // result data
   input  wire status_flags_pkg::flag_mask_s             flag_upd_in,       // flags this op updates
   input  wire status_flags_pkg::alu_flags_s             alu_flags_in,      // flags of this op
   input  wire logic                                     watchdog_clear_in,    // watchdog clear executed
   input  wire logic                                     sleep_in,             // sleep entered
   input  wire logic                                     watchdog_timeout_in,  // watchdog expired
   input  wire logic                                     instr_tick_in,        // instruction cycle tick
   input  wire logic                                     t0_pin_in,            // external timer pin
   input  wire logic                                     watchdog_osc_tick_in, // watchdog oscillator tick
   output logic [7:0]                                    file_rdata_out,    // registered read data
   output logic                                          file_hit_out,      // address is ours
   output logic [7:0]                                    status_out,        // live status value
   output logic                                          indirect_page_bit_out,
   output logic [1:0]                                    direct_bank_out,   // {high, low} page bits
   output logic                                          port_b_pullup_en_out,
   output logic                                          int_edge_rising_out,
   output logic                                          timer_zero_tick_out,
   output logic                                          watchdog_tick_out
);
   import status_flags_pkg::*;

   // elaboration refuses a prescaler too short for the largest ratio
   if (PRESCALE_W < 8) begin
      $error("prescaler needs at least 8 stages");
   end

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   logic       carry_flag;                  // bit 0
   logic       nibble_overflow_bit;         // bit 1
   logic       zero_flag;                   // bit 2
   logic       sleep_entry_flag;            // bit 3, read only
   logic       timeout_flag;                // bit 4, read only
   logic       direct_page_bit_low;         // bit 5
   logic       direct_page_bit_high;        // bit 6
   logic       indirect_page_bit;           // bit 7
   logic [7:0] option_cfg;                  // option register
   logic       status_wr;                   // write aimed at status
   logic       option_wr;                   // write aimed at option
   logic       any_flag_upd;                // op touches alu flags
   logic       next_carry;                  // carry as the op reports it
   logic       next_nibble;                 // nibble carry as the op reports it
   logic [2:0] t0_sync;                     // pin synchroniser
   logic       t0_level;                    // filtered pin level
   logic       t0_level_d;                  // filtered level, one cycle late
   logic       t0_edge;                     // selected pin edge
   logic       t0_source_tick;              // timer input before prescaler
   logic       presc_in;                    // event fed to the prescaler
   logic       presc_out;                   // divided event
   logic [3:0] presc_stages;                // division exponent
   logic       owner_watchdog;              // prescaler owner
   logic       owner_watchdog_d;            // owner last cycle

   // ---------------------------------------------------------------
   // address decode
   // ---------------------------------------------------------------
   // the bank bits are ignored so every alias hits the same flops
   function automatic logic is_status(input logic [FILE_ADDR_W-1:0] addr);
      return addr[BANK_OFS_W-1:0] == STATUS_OFS;
   endfunction

   // option lives in banks 1 and 3 only
   function automatic logic is_option(input logic [FILE_ADDR_W-1:0] addr);
      return addr[OPTION_BANK_BIT] && (addr[BANK_OFS_W-1:0] == OPTION_OFS);
   endfunction

   // write strobes for the two registers
   always_comb begin
      status_wr    = file_wr_in && is_status(file_addr_in);
      option_wr    = file_wr_in && is_option(file_addr_in);
      any_flag_upd = flag_upd_in.zero || flag_upd_in.nibble || flag_upd_in.carry;
   end

   // ---------------------------------------------------------------
   // alu flag sources
   // ---------------------------------------------------------------
   // subtraction reports no-borrow as a set bit
   always_comb begin
      if (alu_flags_in.is_sub) begin
         next_carry  = !alu_flags_in.borrow;
         next_nibble = !alu_flags_in.nibble_borrow;
      end else begin
         next_carry  = alu_flags_in.carry;
         next_nibble = alu_flags_in.nibble_carry;
      end
   end

   // ---------------------------------------------------------------
   // arithmetic flags
   // ---------------------------------------------------------------
   // a flag-updating op owns all three bits; its data write to them is
   // dropped, so a clear of the register still leaves zero set
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         zero_flag           <= STATUS_RESET[ST_ZERO];
         nibble_overflow_bit <= STATUS_RESET[ST_NIBBLE];
         carry_flag          <= STATUS_RESET[ST_CARRY];
      end else if (any_flag_upd) begin
         if (flag_upd_in.zero) begin
            zero_flag <= alu_flags_in.zero;
         end
         if (flag_upd_in.nibble) begin
            nibble_overflow_bit <= next_nibble;
         end
         if (flag_upd_in.carry) begin
            carry_flag <= next_carry;
         end
      end else if (status_wr) begin
         // only ops that leave the flags alone may write them as data
         zero_flag           <= file_wdata_in[ST_ZERO];
         nibble_overflow_bit <= file_wdata_in[ST_NIBBLE];
         carry_flag          <= file_wdata_in[ST_CARRY];
      end
   end

   // ---------------------------------------------------------------
   // bank select bits
   // ---------------------------------------------------------------
   // plain read/write bits
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         indirect_page_bit    <= STATUS_RESET[ST_IPAGE];
         direct_page_bit_high <= STATUS_RESET[ST_DPAGE_HI];
         direct_page_bit_low  <= STATUS_RESET[ST_DPAGE_LO];
      end else if (status_wr) begin
         indirect_page_bit    <= file_wdata_in[ST_IPAGE];
         direct_page_bit_high <= file_wdata_in[ST_DPAGE_HI];
         direct_page_bit_low  <= file_wdata_in[ST_DPAGE_LO];
      end
   end

   // ---------------------------------------------------------------
   // reset-cause flags
   // ---------------------------------------------------------------
   // status writes never reach these; hardware events only
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         timeout_flag     <= STATUS_RESET[ST_TIMEOUT];
         sleep_entry_flag <= STATUS_RESET[ST_SLEEP];
      end else begin
         // expiry wins if it lands with a clear, keeping the cause visible
         if (watchdog_timeout_in) begin
            timeout_flag <= 1'b0;
         end else if (watchdog_clear_in || sleep_in) begin
            timeout_flag <= 1'b1;
         end
         if (sleep_in) begin
            sleep_entry_flag <= 1'b0;
         end else if (watchdog_clear_in) begin
            sleep_entry_flag <= 1'b1;
         end
      end
   end

   // ---------------------------------------------------------------
   // option register
   // ---------------------------------------------------------------
   // fully writable configuration
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         option_cfg <= OPTION_RESET;
      end else if (option_wr) begin
         option_cfg <= file_wdata_in;
      end
   end

   // ---------------------------------------------------------------
   // register views and read port
   // ---------------------------------------------------------------
   // one byte holding every status field
   always_comb begin
      status_out = {indirect_page_bit, direct_page_bit_high, direct_page_bit_low,
                    timeout_flag, sleep_entry_flag, zero_flag,
                    nibble_overflow_bit, carry_flag};
      indirect_page_bit_out = indirect_page_bit;
      direct_bank_out       = {direct_page_bit_high, direct_page_bit_low};
      port_b_pullup_en_out  = !option_cfg[OP_PULLUP_N];
      int_edge_rising_out   = option_cfg[OP_INT_EDGE];
      file_hit_out          = is_status(file_addr_in) || is_option(file_addr_in);
   end

   // read data registered; other addresses read as zero here
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         file_rdata_out <= 8'h00;
      end else if (is_status(file_addr_in)) begin
         file_rdata_out <= status_out;
      end else if (is_option(file_addr_in)) begin
         file_rdata_out <= option_cfg;
      end else begin
         file_rdata_out <= 8'h00;
      end
   end

   // ---------------------------------------------------------------
   // timer pin synchroniser
   // ---------------------------------------------------------------
   // three stages; level moves only when stages two and three agree
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         t0_sync    <= 3'h0;
         t0_level   <= 1'b0;
         t0_level_d <= 1'b0;
      end else begin
         t0_sync    <= {t0_sync[1:0], t0_pin_in};
         t0_level   <= (t0_sync[1] == t0_sync[2]) ? t0_sync[2] : t0_level;
         t0_level_d <= t0_level;
      end
   end

   // ---------------------------------------------------------------
   // prescaler routing
   // ---------------------------------------------------------------
   // edge and source per option; the prescaler serves a single owner
   always_comb begin
      owner_watchdog = option_cfg[OP_ASSIGN];
      if (option_cfg[OP_T0_EDGE]) begin
         t0_edge = t0_level_d && !t0_level;
      end else begin
         t0_edge = !t0_level_d && t0_level;
      end
      t0_source_tick = option_cfg[OP_T0_SRC] ? t0_edge : instr_tick_in;
      presc_in       = owner_watchdog ? watchdog_osc_tick_in : t0_source_tick;
      // timer gets 1:2 and up, watchdog 1:1 and up
      presc_stages   = {1'b0, option_cfg[OP_RATE_HI:OP_RATE_LO]} + {3'h0, !owner_watchdog};
      // without the prescaler the timer sees every event
      timer_zero_tick_out = owner_watchdog ? t0_source_tick : presc_out;
      watchdog_tick_out   = owner_watchdog ? presc_out : watchdog_osc_tick_in;
   end

   // owner change restarts the count so no stale residue leaks across
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         owner_watchdog_d <= OPTION_RESET[OP_ASSIGN];
      end else begin
         owner_watchdog_d <= owner_watchdog;
      end
   end

   shared_prescaler #(
      .WIDTH     (PRESCALE_W)
   ) u_prescaler (
      .clk_in    (clk_in),
      .rst_in    (rst_in),
      .tick_in   (presc_in),
      .clear_in  (owner_watchdog != owner_watchdog_d),
      .stages_in (presc_stages),
      .tick_out  (presc_out)
   );

endmodule

/* verif/status_flags_checker_assertions.sv */
// checker for the status register block ports
`timescale 1ns/100ps
module status_flags_checker
   import status_flags_pkg::*;
#(
   parameter int PRESCALE_W = 8              // mirrors the design count
) (
   input wire logic       clk_in,
   input wire logic       rst_in,
   input wire logic [8:0] file_addr_in,
   input wire logic       file_wr_in,
   input wire logic [7:0] file_wdata_in,
   input wire flag_mask_s flag_upd_in,
   input wire alu_flags_s alu_flags_in,
   input wire logic       watchdog_clear_in,
   input wire logic       sleep_in,
   input wire logic       watchdog_timeout_in,
   input wire logic [7:0] file_rdata_out,
   input wire logic       file_hit_out,
   input wire logic [7:0] status_out,
   input wire logic       indirect_page_bit_out,
   input wire logic [1:0] direct_bank_out
);
   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);
   wire quiet = !watchdog_clear_in && !sleep_in && !watchdog_timeout_in; // no reset-cause event
   wire st_hit = file_addr_in[6:0] == STATUS_OFS;                 // any bank alias
   wire plain_wr = file_wr_in && st_hit && flag_upd_in == 3'h0;   // data-only write

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   chk_reset_value: assert property (disable iff (1'b0) rst_in |=> status_out == 8'h18)
      else $error("status not at reset value");
   chk_status_alias: assert property (plain_wr |=> {status_out[7:5], status_out[2:0]} ==
      {$past(file_wdata_in[7:5]), $past(file_wdata_in[2:0])}) else $error("status write lost");
   chk_flags_readonly: assert property (plain_wr && quiet |=> $stable(status_out[4:3]))
      else $error("reset-cause flag written");
   chk_zero_from_op: assert property (flag_upd_in.zero |=> status_out[2] == $past(alu_flags_in.zero))
      else $error("zero flag not from op");
   chk_flag_hold: assert property (file_wr_in && st_hit && flag_upd_in == 3'h4
      |=> status_out[1:0] == $past(status_out[1:0])) else $error("blocked flags changed");
   chk_sub_borrow: assert property (flag_upd_in.carry && alu_flags_in.is_sub
      |=> status_out[0] == !$past(alu_flags_in.borrow)) else $error("borrow polarity wrong");
   chk_timeout_clear: assert property (watchdog_timeout_in |=> !status_out[4])
      else $error("timeout flag not cleared");
   chk_sleep_clear: assert property (sleep_in && !watchdog_timeout_in |=> status_out[4:3] == 2'b10)
      else $error("sleep flags wrong");
   chk_bank_decode: assert property (st_hit |-> file_hit_out ##0
      {indirect_page_bit_out, direct_bank_out} == status_out[7:5]) else $error("bank decode wrong");
   chk_read_data: assert property (st_hit && !file_wr_in && flag_upd_in == 3'h0 && quiet
      |=> file_rdata_out == status_out) else $error("status read wrong");

   // ---------------------------------------------------------------
   // covers
   // ---------------------------------------------------------------
   cov_plain_write: cover property (plain_wr);
   cov_blocked_write: cover property (file_wr_in && st_hit && flag_upd_in != 3'h0);
   cov_subtract: cover property (flag_upd_in.carry && alu_flags_in.is_sub);
endmodule

bind cpu_status_flags_register status_flags_checker #(.PRESCALE_W(PRESCALE_W)) i_chk (
   .clk_in(clk_in), .rst_in(rst_in), .file_addr_in(file_addr_in), .file_wr_in(file_wr_in),
   .file_wdata_in(file_wdata_in), .flag_upd_in(flag_upd_in), .alu_flags_in(alu_flags_in),
   .watchdog_clear_in(watchdog_clear_in), .sleep_in(sleep_in), .watchdog_timeout_in(watchdog_timeout_in),
   .file_rdata_out(file_rdata_out), .file_hit_out(file_hit_out), .status_out(status_out),
   .indirect_page_bit_out(indirect_page_bit_out), .direct_bank_out(direct_bank_out));

/* verif/cpu_exec_model.sv */
// behavioural instruction unit driving the status block
`timescale 1ns/100ps
module cpu_exec_model (
   input  wire logic                                     clk_in,
   output logic [status_flags_pkg::FILE_ADDR_W-1:0]      file_addr_out,
   output logic                                          file_wr_out,
   output logic [7:0]                                    file_wdata_out,
   output status_flags_pkg::flag_mask_s                  flag_upd_out,
   output status_flags_pkg::alu_flags_s                  alu_flags_out,
   output logic [2:0]                                    event_out     // {timeout, sleep, clear}
);
   import status_flags_pkg::*;
   // idle values at time zero
   initial begin
      file_addr_out = '0;
      file_wr_out = 1'b0;
      file_wdata_out = 8'h00;
      flag_upd_out = '0;
      alu_flags_out = '0;
      event_out = 3'h0;
   end
   // one instruction: result write plus flag update, held for one edge
   task automatic op(input logic [8:0] a, input logic w, input logic [7:0] d,
                     input flag_mask_s u, input alu_flags_s f);
      @(posedge clk_in);
      file_addr_out <= a;
      file_wr_out <= w;
      file_wdata_out <= d;
      flag_upd_out <= u;
      alu_flags_out <= f;
      @(posedge clk_in);
      file_wr_out <= 1'b0;
      flag_upd_out <= '0;
      file_wdata_out <= ~d;                     // released data no longer shows the value
      alu_flags_out <= ~f;
   endtask
   // one reset-cause event pulse
   task automatic ev(input logic [2:0] e);
      @(posedge clk_in);
      event_out <= e;
      @(posedge clk_in);
      event_out <= 3'h0;
   endtask
endmodule

/* verif/tb_cpu_status_flags_register.sv */
// self-checking bench for the status register block
`timescale 1ns/100ps
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin n_errors++; \
   $display("CHECK FAILED t=%0t got %0h exp %0h", $time, got, exp); end end
module tb_cpu_status_flags_register;
   import status_flags_pkg::*;
   logic clk_in, rst_in, instr_tick, osc_tick, t0_pin;
   logic [8:0] addr;
   logic wr, pull_en, edge_r, t_tick, w_tick, ipage, hit;
   logic [7:0] wdata, rdata, st, exp_st;
   logic [1:0] dbank;
   logic [2:0] evt;
   flag_mask_s upd;
   alu_flags_s alu;
   int n_errors = 0;
   int checks_done = 0;
   int ct, cw;
   // option value, expected timer and watchdog ticks over 16 source ticks
   logic [7:0] opt_tab [4] = '{8'h08, 8'h00, 8'h0A, 8'h02};
   int t_tab [4] = '{16, 8, 16, 2};
   int w_tab [4] = '{16, 16, 4, 16};
   logic [2:0] ev_tab [4] = '{3'b100, 3'b010, 3'b001, 3'b110};
   logic [1:0] ev_exp [4] = '{2'b01, 2'b10, 2'b11, 2'b00};

   cpu_exec_model i_cpu (.clk_in(clk_in), .file_addr_out(addr), .file_wr_out(wr), .file_wdata_out(wdata),
      .flag_upd_out(upd), .alu_flags_out(alu), .event_out(evt));
   cpu_status_flags_register #(.PRESCALE_W(8)) i_dut (.clk_in(clk_in), .rst_in(rst_in),
      .file_addr_in(addr), .file_wr_in(wr), .file_wdata_in(wdata), .flag_upd_in(upd),
      .alu_flags_in(alu), .watchdog_clear_in(evt[0]), .sleep_in(evt[1]), .watchdog_timeout_in(evt[2]),
      .instr_tick_in(instr_tick), .t0_pin_in(t0_pin), .watchdog_osc_tick_in(osc_tick),
      .file_rdata_out(rdata), .file_hit_out(hit), .status_out(st), .indirect_page_bit_out(ipage),
      .direct_bank_out(dbank), .port_b_pullup_en_out(pull_en), .int_edge_rising_out(edge_r),
      .timer_zero_tick_out(t_tick), .watchdog_tick_out(w_tick));

   // ---------------------------------------------------------------
   // clock, watchdog, verdict
   // ---------------------------------------------------------------
   initial begin
      clk_in = 1'b0;
      forever #2 clk_in = ~clk_in;
   end
   initial begin
      #40000;
      n_errors++;                               // the tests hung
      results();
   end
   task automatic results();
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // source ticks every other cycle, outputs counted mid-cycle
   task automatic ticks(input int n);
      ct = 0;
      cw = 0;
      repeat (n) begin
         @(posedge clk_in);
         instr_tick <= 1'b1;
         osc_tick <= 1'b1;
         @(negedge clk_in);
         ct += int'(t_tick === 1'b1);
         cw += int'(w_tick === 1'b1);
         @(posedge clk_in);
         instr_tick <= 1'b0;
         osc_tick <= 1'b0;
      end
   endtask
   // pin toggles every eight cycles; ticks after a rise go to ct, after a fall to cw
   task automatic pulses(input int n);
      ct = 0;
      cw = 0;
      repeat (2 * n) begin
         @(posedge clk_in);
         t0_pin <= ~t0_pin;
         repeat (8) begin
            @(negedge clk_in);
            if (t0_pin) ct += int'(t_tick === 1'b1);
            else cw += int'(t_tick === 1'b1);
         end
      end
   endtask

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      rst_in = 1'b1;
      instr_tick = 1'b0;
      osc_tick = 1'b0;
      t0_pin = 1'b0;
      repeat (8) @(posedge clk_in);
      rst_in <= 1'b0;
      #1 `CHK(st, 8'h18)
      i_cpu.op(9'h081, 1'b0, 8'h00, 3'h0, 6'h00);
      #1 `CHK({rdata, pull_en, edge_r}, {8'hFF, 2'b01})
      exp_st = 8'h18;
      // writes through every bank alias, read back through another
      for (int i = 0; i < 4; i++) begin
         i_cpu.op({2'(i), 7'h03}, 1'b1, 8'hFF - 8'(i * 37), 3'h0, 6'h00);
         exp_st = ((8'hFF - 8'(i * 37)) & 8'hE7) | 8'h18;
         #1 `CHK(st, exp_st)
         `CHK({ipage, dbank}, exp_st[7:5])
         i_cpu.op({~2'(i), 7'h03}, 1'b0, 8'h00, 3'h0, 6'h00);
         #1 `CHK(rdata, exp_st)
      end
      // clear-style write: only zero updated, data blocked from the flags but written to the page bits
      i_cpu.op(9'h083, 1'b1, 8'h00, 3'h4, 6'h20);
      exp_st = 8'h1C | (exp_st & 8'h03);
      #1 `CHK(st, exp_st)
      // subtract with status as destination: borrow inverted
      i_cpu.op(9'h103, 1'b1, 8'hFF, 3'h7, 6'h05);
      exp_st = 8'hE2 | (exp_st & 8'h18);
      #1 `CHK(st, exp_st)
      i_cpu.op(9'h010, 1'b0, 8'h00, 3'h7, 6'h10);
      #1 `CHK(st[2:0], 3'b001)
      // reset-cause events and one collision, timeout with sleep
      for (int i = 0; i < 4; i++) begin
         i_cpu.ev(ev_tab[i]);
         #1 `CHK(st[4:3], ev_exp[i])
      end
      i_cpu.op(9'h001, 1'b0, 8'h00, 3'h0, 6'h00);
      #1 `CHK({hit, rdata}, 9'h000)
      // prescaler ownership and ratios, owner flips on every step after the first
      for (int i = 0; i < 4; i++) begin
         i_cpu.op(9'h181, 1'b1, opt_tab[i], 3'h0, 6'h00);
         #1 `CHK({pull_en, edge_r}, 2'b10)
         ticks(16);
         `CHK(ct, t_tab[i])
         `CHK(cw, w_tab[i])
      end
      // pin as timer source, prescaler with the watchdog: rising edges, then falling
      i_cpu.op(9'h181, 1'b1, 8'h28, 3'h0, 6'h00);
      pulses(4);
      `CHK(ct, 4)
      `CHK(cw, 0)
      i_cpu.op(9'h181, 1'b1, 8'h38, 3'h0, 6'h00);
      pulses(4);
      `CHK(ct, 0)
      `CHK(cw, 4)
      results();
   end
endmodule
